// File: inc/apc_pkg.sv
// Notes on behaviour
// - Chip select high: ignore strobes, float bus
// - Write strobe latches eight-bit control word
// - Unipolar straight binary, bipolar two's complement
// - Byte select low: result bits 7..0
// - Byte select high: bits 9,8, sign fill when bipolar, zero fill when unipolar
// - Control word field layout, bit 7 down
// - Single-ended: input n against common return
// - Pseudo-differential pairs, bit 0 picks polarity
// - Reset: external clock, done flag high
// - Ten microsecond internal reset, no conversions
// - Power-down keeps port alive, no converting
// - Standby wakes on write strobe rise
// - Shutdown waits for running conversion end
// - Write strobe rise leaves shutdown
// - One step per reference over 1024
// - Sequential cycle: 1+3+13+2 clocks
// - Overlapped write shortens cycle to 16
// - Done flag low on result, high on access
// - Power field encodings and clock mode
`default_nettype none
package apc_pkg;
    // ***********************************
    // Clock and widths
    // ***********************************
    localparam int REF_CLK_MHZ = 200;  // Core clock rate
    localparam int RES_BITS    = 10;   // Result width
    localparam int CTRL_BITS   = 8;    // Control word width
    localparam int CH_BITS     = 3;    // Channel field width

    // ***********************************
    // Control word field positions
    // ***********************************
    localparam int PWR_HI_POS = 7;  // Power select high bit
    localparam int PWR_LO_POS = 6;  // Power select low bit
    localparam int ACQ_POS    = 5;  // Sample mode select
    localparam int CFG_POS    = 4;  // Input config select
    localparam int POL_POS    = 3;  // Polarity select
    localparam int CH_HI_POS  = 2;  // Channel field top bit

    // ***********************************
    // Power select encodings
    // ***********************************
    localparam logic [1:0] PWR_SHDN = 2'h0;  // Full shutdown
    localparam logic [1:0] PWR_STBY = 2'h1;  // Standby
    localparam logic [1:0] PWR_INT  = 2'h2;  // Normal, internal clock
    localparam logic [1:0] PWR_EXT  = 2'h3;  // Normal, external clock

    // Reset word: normal power, external clock, unipolar
    localparam logic [7:0] CTRL_RST = 8'hD8;

    // ***********************************
    // Timing
    // ***********************************
    localparam int POR_TIME_NS = 10000;  // Internal reset time
    // Least time, so rounded up
    localparam int POR_CYCLES =
        (POR_TIME_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int ACQ_CYCLES  = 3;   // Acquisition clocks
    localparam int CONV_CYCLES = 13;  // Conversion clocks
    // Internal clock: whole conversion in 3.6 us
    localparam int INT_CONV_TIME_NS = 3600;
    // Longest period per step, so rounded down
    localparam int INT_DIV_CYCLES =
        (INT_CONV_TIME_NS * REF_CLK_MHZ) / (1000 * CONV_CYCLES);
endpackage
`default_nettype wire

// File: logic/apc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module apc_ctrl #(
    parameter int NUM_INPUTS = 8,
    parameter int INT_DIV    = apc_pkg::INT_DIV_CYCLES
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          cs_n,
    input  wire logic                          wr_n,
    input  wire logic                          rd_n,
    input  wire logic                          upper_byte_select,
    input  wire logic                          conv_clk,
    input  wire logic [apc_pkg::CTRL_BITS-1:0] data_in,
    output logic [apc_pkg::CTRL_BITS-1:0]      data_out,
    output logic                               data_oe,
    output logic                               done_n,
    input  wire logic                          cmp_in,
    output logic [apc_pkg::RES_BITS-1:0]       trial_code,
    output logic                               track_en,
    output logic [apc_pkg::CH_BITS-1:0]        pos_sel,
    output logic [apc_pkg::CH_BITS-1:0]        neg_sel,
    output logic                               neg_is_com,
    output logic                               ext_clk_mode,
    output logic                               standby,
    output logic                               shutdown
);
    // ***********************************
    // Elaboration checks
    // ***********************************
    // Only the four and eight input variants exist
    if (NUM_INPUTS != 4 && NUM_INPUTS != 8) begin : g_chk_in
        $error("apc_ctrl: NUM_INPUTS must be 4 or 8");
    end
    // Divider counter is six bits wide
    if (INT_DIV < 1 || INT_DIV > 64) begin : g_chk_div
        $error("apc_ctrl: INT_DIV out of range");
    end

    // ***********************************
    // Types
    // ***********************************
    // Main sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_POR  = 6'h01,  // Internal reset running
        ST_IDLE = 6'h02,  // Powered, waiting for a word
        ST_ACQ  = 6'h04,  // Tracking the input
        ST_CONV = 6'h08,  // Approximation running
        ST_STBY = 6'h10,  // Standby power-down
        ST_SHDN = 6'h20   // Full shutdown
    } apc_state_t;

    // All control state of the block
    typedef struct packed {
        apc_state_t                     st;       // Sequencer
        logic [apc_pkg::CTRL_BITS-1:0]  ctrl;     // Active word
        logic                           ext_clk;  // Clock mode
        logic                           wr_lo;    // Write strobe held
        logic [apc_pkg::CTRL_BITS-1:0]  din;      // Bus sample
        logic                           clk_hi;   // Gated pin clock
        logic [11:0]                    cnt;      // Reset / acq count
        logic [5:0]                     div;      // Internal divider
        logic                           tick;     // Internal step
        logic [apc_pkg::RES_BITS-1:0]   res;      // Formatted result
        logic                           bip;      // Result polarity
        logic                           done_n;   // Done flag
        logic [apc_pkg::CTRL_BITS-1:0]  dout;     // Bus drive value
        logic                           oe;       // Bus enable
        logic                           track;    // Track enable
        logic                           go;       // SAR start pulse
        logic [apc_pkg::CH_BITS-1:0]    pos;      // Positive input
        logic [apc_pkg::CH_BITS-1:0]    neg;      // Negative input
        logic                           neg_com;  // Negative is common
        logic                           stby;     // Standby flag
        logic                           shdn;     // Shutdown flag
    } apc_regs_t;

    // ***********************************
    // Constants local to this block
    // ***********************************
    localparam logic [11:0] POR_LAST = 12'(apc_pkg::POR_CYCLES - 1);
    localparam logic [11:0] ACQ_LAST = 12'(apc_pkg::ACQ_CYCLES - 1);
    localparam logic [5:0]  DIV_LAST = 6'(INT_DIV - 1);

    // ***********************************
    // Signals
    // ***********************************
    apc_regs_t s_r;    // Registered state
    apc_regs_t s_nxt;  // Next state

    logic                          wr_rise;   // End of a write
    logic                          rd_lo;     // Read access active
    logic                          clk_rise;  // Pin clock edge
    logic                          step;      // One conversion clock
    logic                          sar_done;  // Result ready pulse
    logic [apc_pkg::RES_BITS-1:0]  sar_res;   // Raw offset code
    logic [apc_pkg::RES_BITS-1:0]  fmt_res;   // Result after polarity
    logic [1:0]                    new_pwr;   // Latched power field
    logic [1:0]                    act_pwr;   // Active power field
    logic [apc_pkg::CH_BITS-1:0]   new_ch;    // Latched channel

    // ***********************************
    // Strobe and clock qualification
    // ***********************************
    // Strobes count only while chip select is low
    assign wr_rise  = s_r.wr_lo & (wr_n | cs_n);
    assign rd_lo    = ~rd_n & ~cs_n;
    // Pin clock ignored while deselected
    assign clk_rise = ~cs_n & conv_clk & ~s_r.clk_hi;
    // Conversion clock from pin or internal divider
    assign step     = s_r.ext_clk ? clk_rise : s_r.tick;

    // ***********************************
    // Field extraction
    // ***********************************
    assign new_pwr = s_r.din[apc_pkg::PWR_HI_POS:apc_pkg::PWR_LO_POS];
    assign act_pwr = s_r.ctrl[apc_pkg::PWR_HI_POS:apc_pkg::PWR_LO_POS];
    // Small variant has no upper four inputs
    assign new_ch = (NUM_INPUTS == 4)
        ? {1'b0, s_r.din[apc_pkg::CH_HI_POS-1:0]}
        : s_r.din[apc_pkg::CH_HI_POS:0];

    // Bipolar flips the MSB of the offset code
    assign fmt_res = s_r.ctrl[apc_pkg::POL_POS]
        ? sar_res
        : {~sar_res[apc_pkg::RES_BITS-1],
           sar_res[apc_pkg::RES_BITS-2:0]};

    // ***********************************
    // Approximation engine
    // ***********************************
    apc_sar #(
        .BITS  (apc_pkg::RES_BITS),
        .STEPS (apc_pkg::CONV_CYCLES)
    ) u_sar (
        .ref_clk (ref_clk),
        .rst     (rst),
        .start   (s_r.go),
        .step    (step),
        .cmp_in  (cmp_in),
        .trial   (trial_code),
        .result  (sar_res),
        .done    (sar_done)
    );

    // ***********************************
    // Next-state logic
    // ***********************************
    always_comb begin
        s_nxt      = s_r;
        s_nxt.go   = 1'b0;
        s_nxt.tick = 1'b0;

        // Sample pins every cycle
        s_nxt.wr_lo  = ~wr_n & ~cs_n;
        s_nxt.clk_hi = conv_clk & ~cs_n;
        if (~wr_n & ~cs_n) begin
            // Hold the last bus value seen in the strobe
            s_nxt.din = data_in;
        end

        // Internal clock divider, idle in external mode
        if (s_r.ext_clk) begin
            s_nxt.div = 6'h00;
        end else if (s_r.div == DIV_LAST) begin
            s_nxt.div  = 6'h00;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 6'h01;
        end

        // Read side: bus enable follows the access
        s_nxt.oe = rd_lo;
        if (upper_byte_select) begin
            // Top two bits, sign filled when bipolar
            s_nxt.dout = {{6{s_r.bip & s_r.res[9]}}, s_r.res[9:8]};
        end else begin
            s_nxt.dout = s_r.res[7:0];
        end
        // First read cycle releases the done flag
        if (rd_lo) begin
            s_nxt.done_n = 1'b1;
        end

        // Sequencer
        case (s_r.st)
            ST_POR: begin
                // Writes are not honoured until reset ends
                if (s_r.cnt == POR_LAST) begin
                    s_nxt.cnt = 12'h000;
                    s_nxt.st  = ST_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt + 12'h001;
                end
            end
            ST_ACQ: begin
                if (s_r.ctrl[apc_pkg::ACQ_POS]) begin
                    // External acquisition: next write ends tracking
                    if (wr_rise) begin
                        s_nxt.track = 1'b0;
                        s_nxt.go    = 1'b1;
                        s_nxt.st    = ST_CONV;
                    end
                end else if (step) begin
                    if (s_r.cnt == ACQ_LAST) begin
                        s_nxt.track = 1'b0;
                        s_nxt.go    = 1'b1;
                        s_nxt.st    = ST_CONV;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 12'h001;
                    end
                end
            end
            ST_CONV: begin
                if (sar_done) begin
                    // Result stays until the next completion
                    s_nxt.res    = fmt_res;
                    s_nxt.bip    = ~s_r.ctrl[apc_pkg::POL_POS];
                    s_nxt.done_n = 1'b0;
                    // Power-down only after the conversion ends
                    case (act_pwr)
                        apc_pkg::PWR_SHDN: begin
                            s_nxt.st   = ST_SHDN;
                            s_nxt.shdn = 1'b1;
                        end
                        apc_pkg::PWR_STBY: begin
                            s_nxt.st   = ST_STBY;
                            s_nxt.stby = 1'b1;
                        end
                        default: begin
                            s_nxt.st = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_IDLE, ST_STBY, ST_SHDN: begin
                // Port stays live; nothing converts here
                s_nxt.track = 1'b0;
            end
            default: begin
                s_nxt.st = ST_POR;
            end
        endcase

        // New control word, outside the reset phase and external-acquisition tracking
        if (wr_rise && (s_r.st != ST_POR) &&
            !(s_r.st == ST_ACQ && s_r.ctrl[apc_pkg::ACQ_POS])) begin
            s_nxt.ctrl = s_r.din;
            // Power-down codes keep the old clock mode
            if (new_pwr == apc_pkg::PWR_INT) begin
                s_nxt.ext_clk = 1'b0;
            end else if (new_pwr == apc_pkg::PWR_EXT) begin
                s_nxt.ext_clk = 1'b1;
            end
            // Wake from either power-down on the write edge
            s_nxt.stby  = 1'b0;
            s_nxt.shdn  = 1'b0;
            // Overlapped write restarts tracking at once
            s_nxt.st    = ST_ACQ;
            s_nxt.cnt   = 12'h000;
            s_nxt.track = 1'b1;
            // A completion in the same cycle keeps the flag low
            if (!(s_r.st == ST_CONV && sar_done)) begin
                s_nxt.done_n = 1'b1;
            end
            // Input routing from the new word
            if (s_r.din[apc_pkg::CFG_POS]) begin
                s_nxt.pos     = new_ch;
                s_nxt.neg     = new_ch;
                s_nxt.neg_com = 1'b1;
            end else begin
                // Pair chosen by upper bits, bit 0 picks the plus side
                s_nxt.pos     = new_ch;
                s_nxt.neg     = {new_ch[2:1], ~new_ch[0]};
                s_nxt.neg_com = 1'b0;
            end
        end

        // A completion in the same cycle as a read wins
        if (s_r.st == ST_CONV && sar_done) begin
            s_nxt.done_n = 1'b0;
        end
    end

    // ***********************************
    // State register
    // ***********************************
    // Reset acts as the power-on reset of the part
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r         <= '0;
            s_r.st      <= ST_POR;
            s_r.ctrl    <= apc_pkg::CTRL_RST;
            s_r.ext_clk <= 1'b1;
            s_r.done_n  <= 1'b1;
            s_r.neg_com <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ***********************************
    // Outputs, all from flops
    // ***********************************
    assign data_out     = s_r.dout;
    assign data_oe      = s_r.oe;
    assign done_n       = s_r.done_n;
    assign track_en     = s_r.track;
    assign pos_sel      = s_r.pos;
    assign neg_sel      = s_r.neg;
    assign neg_is_com   = s_r.neg_com;
    assign ext_clk_mode = s_r.ext_clk;
    assign standby      = s_r.stby;
    assign shutdown     = s_r.shdn;
endmodule
`default_nettype wire

// File: logic/apc_sar.sv
`timescale 1ns/1ps
`default_nettype none
module apc_sar #(
    parameter int BITS  = 10,
    parameter int STEPS = 13
) (
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic            start,
    input  wire logic            step,
    input  wire logic            cmp_in,
    output logic [BITS-1:0]      trial,
    output logic [BITS-1:0]      result,
    output logic                 done
);
    // ***********************************
    // Elaboration checks
    // ***********************************
    if (BITS < 2 || STEPS < BITS || STEPS > 15) begin : g_chk
        $error("apc_sar: unsupported BITS or STEPS");
    end

    // ***********************************
    // State
    // ***********************************
    typedef struct packed {
        logic            busy;  // Conversion running
        logic [3:0]      cnt;   // Step counter
        logic [BITS-1:0] mask;  // Bit under trial
        logic [BITS-1:0] code;  // Trial code to DAC
        logic [BITS-1:0] res;   // Last result
        logic            done;  // Done pulse
    } apc_sar_t;

    apc_sar_t s_r;    // Registered state
    apc_sar_t s_nxt;  // Next state

    // Bit decisions, then idle steps to fill the cycle count
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (start) begin
            // Restart wins over a pending step
            s_nxt.busy = 1'b1;
            s_nxt.cnt  = 4'h0;
            s_nxt.mask = {1'b1, {(BITS-1){1'b0}}};
            s_nxt.code = {1'b1, {(BITS-1){1'b0}}};
        end else if (s_r.busy && step) begin
            if (s_r.mask != '0) begin
                // Comparator high: input above trial minus half step
                s_nxt.code = (cmp_in ? s_r.code : (s_r.code & ~s_r.mask))
                             | (s_r.mask >> 1);
                s_nxt.mask = s_r.mask >> 1;
            end
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_r.cnt == 4'(STEPS - 1)) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.res  = s_r.code;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign trial  = s_r.code;
    assign result = s_r.res;
    assign done   = s_r.done;
endmodule
`default_nettype wire

// File: verification/apc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// Front end: the selected input sits on the centre of code 'level'
module apc_analog_model (
    input  wire logic [apc_pkg::RES_BITS-1:0] trial_code,
    input  wire logic [apc_pkg::RES_BITS-1:0] level,
    output logic                              cmp_in
);
    // Threshold is half a step below the trial code, so a code
    // centre never sits on a threshold and no tie arises
    assign cmp_in = (level >= trial_code);
endmodule
`default_nettype wire

// File: verification/apc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module apc_ctrl_checker (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       upper_byte_select,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic       done_n,
    input wire logic [2:0] pos_sel,
    input wire logic [2:0] neg_sel,
    input wire logic       neg_is_com,
    input wire logic       ext_clk_mode,
    input wire logic       standby,
    input wire logic       shutdown,
    input wire logic       track_en
);
    // ***********************************
    // Port rules
    // ***********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_reset_defaults: assert property (disable iff (1'b0) rst |=>
        done_n && ext_clk_mode && !data_oe) else $error("bad reset state");
    a_cs_float: assert property (cs_n |=> !data_oe)
        else $error("bus driven while deselected");
    a_cs_no_write: assert property (cs_n [*3] |=>
        $stable(ext_clk_mode) && $stable(pos_sel))
        else $error("word taken while deselected");
    a_read_drives: assert property (!cs_n && !rd_n |=> data_oe)
        else $error("read not driven");
    a_upper_fill: assert property (data_oe && $past(upper_byte_select)
        |-> data_out[7:2] == 6'h00 || data_out[7:2] == {6{data_out[1]}})
        else $error("bad upper fill");
    a_pair_adjacent: assert property (!neg_is_com |->
        neg_sel == (pos_sel ^ 3'h1)) else $error("bad input pair");
    a_power_excl: assert property (!(standby && shutdown))
        else $error("two power states");
    a_no_track_down: assert property (track_en |->
        !standby && !shutdown) else $error("tracking while down");
    a_done_holds: assert property (cs_n [*3] ##0 !done_n |=> !done_n)
        else $error("done released without access");
    // Main scenarios reached
    c_upper_read: cover property (!cs_n && !rd_n && upper_byte_select);
    c_done: cover property ($fell(done_n));
    c_standby: cover property ($rose(standby));
    c_shutdown: cover property ($rose(shutdown));
endmodule
bind apc_ctrl apc_ctrl_checker u_chk (.*);
`default_nettype wire

// File: verification/test_adc_parallel_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_parallel_control;
    // ***********************************
    // Stimulus and wiring
    // ***********************************
    logic       ref_clk = 1'h0;
    logic       rst = 1'h1;
    logic       cs_n = 1'h1;
    logic       wr_n = 1'h1;
    logic       rd_n = 1'h1;
    logic       upper_byte_select = 1'h0;
    logic       conv_clk = 1'h0;
    logic [7:0] data_in = 8'h00;
    logic [9:0] level = 10'h000;
    logic [7:0] data_out;
    logic       data_oe;
    logic       done_n;
    logic       cmp_in;
    logic [9:0] trial_code;
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
    logic       neg_is_com;
    logic       ext_clk_mode;
    logic       standby;
    logic       shutdown;
    logic       track_en;
    logic       ext_m = 1'h1;  // Clock mode the bench expects
    int         n_errors = 0;
    int         checks = 0;
    // Half pin clock period: 70 ns keeps the pin under 7.6 MHz
    localparam int PIN_HALF = 14;
    // Small divider keeps internal conversions short
    apc_ctrl #(.INT_DIV(2)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .upper_byte_select(upper_byte_select), .conv_clk(conv_clk),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .done_n(done_n), .cmp_in(cmp_in), .trial_code(trial_code),
        .track_en(track_en), .pos_sel(pos_sel), .neg_sel(neg_sel),
        .neg_is_com(neg_is_com), .ext_clk_mode(ext_clk_mode),
        .standby(standby), .shutdown(shutdown));
    apc_analog_model u_fe (.trial_code(trial_code), .level(level),
        .cmp_in(cmp_in));
    // 200 MHz core clock
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ***********************************
    // Checks and expectations
    // ***********************************
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk({9'h000, g}, {9'h000, e});
    endtask
    // Bipolar result is the offset code with the top bit inverted
    function automatic logic [9:0] code(logic [9:0] l, logic uni);
        return uni ? l : l ^ 10'h200;
    endfunction
    function automatic logic [7:0] hi(logic [9:0] c, logic uni);
        return {{6{c[9] & ~uni}}, c[9:8]};
    endfunction
    // ***********************************
    // Bus cycles
    // ***********************************
    task automatic wr(input logic [7:0] w);
        // Power-down codes keep the clock mode
        if (w[7]) ext_m = w[6];
        @(posedge ref_clk);
        cs_n <= 1'h0;
        wr_n <= 1'h0;
        data_in <= w;
        @(posedge ref_clk);
        wr_n <= 1'h1;
        data_in <= ~w;  // Released bus no longer shows the word
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rd(input logic ub, output logic [7:0] q);
        @(posedge ref_clk);
        cs_n <= 1'h0;
        rd_n <= 1'h0;
        upper_byte_select <= ub;
        @(posedge ref_clk);
        #1;
        q = data_out;
        chk1(data_oe, 1'h1);
        @(posedge ref_clk);
        rd_n <= 1'h1;
    endtask
    // One period of the pin clock, idle low in internal mode
    task automatic pin_clk();
        conv_clk <= ext_m;
        repeat (PIN_HALF) @(posedge ref_clk);
        conv_clk <= 1'h0;
        repeat (PIN_HALF) @(posedge ref_clk);
    endtask
    // Write, then clock the conversion until done falls
    task automatic conv(input logic [7:0] w, input logic [9:0] l);
        int n;
        n = 0;
        level = l;
        wr(w);
        chk1(done_n, 1'h1);
        chk1(ext_clk_mode, ext_m);
        chk({7'h00, pos_sel}, {7'h00, w[2:0]});
        chk1(neg_is_com, w[4]);
        if (!w[4]) chk({7'h00, neg_sel}, {7'h00, w[2:0] ^ 3'h1});
        while (done_n !== 1'h0 && n < 40) begin
            pin_clk();
            n++;
        end
        if (ext_m) chk(10'(n), 10'h010);
        chk1(done_n, 1'h0);
        repeat (2) @(posedge ref_clk);
        chk1(standby, w[7:6] == 2'h1);
        chk1(shutdown, w[7:6] == 2'h0);
    endtask
    // ***********************************
    // Main sequence
    // ***********************************
    task automatic stop_test();
        if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        stop_test();
    end
    initial begin
        logic [7:0] w;
        logic [7:0] q;
        logic [9:0] l;
        logic [9:0] c;
        void'($urandom(5670));
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        #1;
        chk1(done_n, 1'h1);
        chk1(ext_clk_mode, 1'h1);
        wr(8'h88);  // Too early: must be ignored
        chk1(ext_clk_mode, 1'h1);
        repeat (2010) @(posedge ref_clk);
        for (int i = 0; i < 24; i++) begin
            w = {1'h1, 1'($urandom), 1'h0, 5'($urandom)};
            l = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom);
            conv(w, l);
            c = code(l, w[3]);
            if (i % 4 == 3) wr(w);  // Next word before reading
            rd(1'h0, q);
            chk({2'h0, q}, {2'h0, c[7:0]});
            chk1(done_n, 1'h1);
            rd(1'h1, q);
            chk({2'h0, q}, {2'h0, hi(c, w[3])});
        end
        // External acquisition: the second write only ends tracking
        level = 10'h2C5;
        wr(8'hF9);
        chk1(track_en, 1'h1);
        wr(8'h00);
        chk1(track_en, 1'h0);
        chk({7'h00, pos_sel}, 10'h001);
        repeat (13) pin_clk();
        chk1(done_n, 1'h0);
        rd(1'h0, q);
        chk({2'h0, q}, 10'h0C5);
        conv(8'h58, 10'h155);  // Dummy conversion into standby
        wr(8'hD8);
        chk1(standby, 1'h0);
        conv(8'h18, 10'h2AA);
        wr(8'hD8);
        chk1(shutdown, 1'h0);
        // External reference settles in 50 us before use
        repeat (10000) @(posedge ref_clk);
        conv(8'hDB, 10'h3C3);
        // Deselected: strobes, pin clock and read all ignored
        @(posedge ref_clk);
        cs_n <= 1'h1;
        rd_n <= 1'h0;
        wr_n <= 1'h0;
        data_in <= 8'h97;
        conv_clk <= 1'h1;
        repeat (4) @(posedge ref_clk);
        wr_n <= 1'h1;
        conv_clk <= 1'h0;
        repeat (4) @(posedge ref_clk);
        chk1(data_oe, 1'h0);
        chk1(done_n, 1'h0);
        chk1(ext_clk_mode, 1'h1);
        chk({7'h00, pos_sel}, 10'h003);
        rd_n <= 1'h1;
        stop_test();
    end
endmodule
`default_nettype wire
